// *** inc/cit_defs.vh ***
// Constants for the CAN interrupt-code, timestamp and pin-control tail block
`ifndef CIT_DEFS_VH
`define CIT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (4-bit port address)
// ----------------------------------------------------------------
`define CIT_ADDR_W          4
`define CIT_REG_FLAG        4'h0
`define CIT_REG_ENABLE      4'h1
`define CIT_REG_CTRLSTAT    4'h2
`define CIT_REG_PINCTRL     4'h3
`define CIT_REG_BITTIME     4'h4
`define CIT_REG_COMMSTAT    4'h5
`define CIT_REG_IRQSTAT     4'h6
`define CIT_REG_IRQMASK     4'h7

// ----------------------------------------------------------------
// Flag / enable bit positions
// ----------------------------------------------------------------
`define CIT_B_ERR           0
`define CIT_B_TXA           1
`define CIT_B_TXB           2
`define CIT_B_TXC           3
`define CIT_B_RXA           4
`define CIT_B_RXB           5
`define CIT_B_WAK           6

// ----------------------------------------------------------------
// Priority codes
// ----------------------------------------------------------------
`define CIT_CODE_NONE       3'h0
`define CIT_CODE_ERR        3'h1
`define CIT_CODE_TXA        3'h4
`define CIT_CODE_TXB        3'h3
`define CIT_CODE_TXC        3'h2
`define CIT_CODE_RXA        3'h6
`define CIT_CODE_RXB        3'h5
`define CIT_CODE_WAK        3'h7

// ----------------------------------------------------------------
// Operating modes (ctrl/status bits 7:5)
// ----------------------------------------------------------------
`define CIT_MODE_NORMAL     3'h0
`define CIT_MODE_DISABLE    3'h1
`define CIT_MODE_LOOPBACK   3'h2
`define CIT_MODE_LISTEN     3'h3
`define CIT_MODE_CONFIG     3'h4

// ----------------------------------------------------------------
// Pin-control bits, status-event bits, reset values
// ----------------------------------------------------------------
`define CIT_PC_TX2EN        0
`define CIT_PC_RECDRV       1
`define CIT_EV_TSTAMP       0
`define CIT_EV_IRQCODE      1
`define CIT_RST_PINCTRL     8'h00
`define CIT_RST_BITTIME     8'h13
`define CIT_RST_MODE        3'h4
`define CIT_BT_W            8

`endif

// *** rtl/cit_can_tail.v ***
// Top of the CAN tail: interrupt code, timestamp, pin control, registers
// Overview of operation
// - Source counts only when flag and enabled
// - Code reports highest-priority source, else 000
// - Timestamp signal on each accepted frame
// - Pulse after clean EOF, one bit time
// - Up to three pins shared with port
// - Config, disable, loopback return pins to port
// - Active: primary tx pin carries CAN output
// - Secondary tx pin only when enabled
// - Drive-select clear: actively drive recessive level
// - CAN drive overrides port direction bits
// - Receive data from one input pin
// - Reset enters initialization mode automatically
// - Code shows next source after clearing
// - Several error conditions set one flag
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "cit_defs.vh"

module cit_can_tail (
    // Clock and reset
    input  wire                   mclk,
    input  wire                   arst_n,
    // Register port
    input  wire [`CIT_ADDR_W-1:0] regAddr,
    input  wire [7:0]             regWdata,
    input  wire                   regWrite,
    input  wire                   regRead,
    output reg  [7:0]             regRdata_ff,
    // Events from the protocol engine (same clock)
    input  wire [6:0]             irqSetEvents,
    input  wire [4:0]             errConditions,
    input  wire                   frameValidEof,
    input  wire                   canTxBit,
    // Port logic, one bit per shared pin (0 tx1, 1 tx2, 2 rx)
    input  wire [2:0]             portOut,
    input  wire [2:0]             port_direction_bits,
    // Pads
    input  wire                   rxPinIn,
    output reg                    primary_tx_pin_o_ff,
    output reg                    primary_tx_pin_oe_ff,
    output reg                    secondary_tx_pin_o_ff,
    output reg                    secondary_tx_pin_oe_ff,
    output reg                    rxPinOe_ff,
    output reg                    rxPinO_ff,
    // To protocol engine and timers
    output reg                    canRxBit_ff,
    output reg                    portRxBit_ff,
    output wire                   tstampPulse_ff,
    output reg  [2:0]             canMode_ff,
    output reg                    irq_ff
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [6:0]            irqFlag_ff;
    reg  [6:0]            irqEnable_ff;
    reg  [7:0]            can_pin_control_reg_ff;
    reg  [`CIT_BT_W-1:0]  bitTime_ff;
    reg  [4:0]            comm_status_reg_ff;
    reg  [1:0]            evtStat_ff;
    reg  [1:0]            evtMask_ff;
    reg  [2:0]            prevCode_ff;
    reg                   rxMeta_ff;
    reg                   rxSync_ff;
    reg  [7:0]            nxt_rdata;
    reg  [6:0]            nxt_flag;
    reg  [1:0]            nxt_evt;
    reg                   nxt_txOe;
    reg                   nxt_txO;
    wire [2:0]            irqPriorityCode;
    wire [6:0]            setVec;
    wire                  canOwnsPins;
    wire                  codeChanged;

    // ----------------------------------------------------------------
    // Interrupt code
    // ----------------------------------------------------------------
    // Combinational encoder: the code follows flag and enable every cycle
    cit_prio_enc u_enc (
        .irqFlags   (irqFlag_ff),
        .irqEnables (irqEnable_ff),
        .irqCode    (irqPriorityCode)
    );

    // Any error condition lands on the one error flag
    assign setVec = irqSetEvents | {6'h00, |errConditions};

    // Flags: hardware set wins over a software clear in the same cycle
    always @* begin
        nxt_flag = irqFlag_ff;
        if (regWrite && regAddr == `CIT_REG_FLAG)
            nxt_flag = regWdata[6:0];
        nxt_flag = nxt_flag | setVec;
    end

    // ----------------------------------------------------------------
    // Timestamp
    // ----------------------------------------------------------------
    // Only frames seen while the controller is on the bus count
    cit_tstamp u_ts (
        .mclk           (mclk),
        .arst_n         (arst_n),
        .frameOk        (frameValidEof && canOwnsPins),
        .bitTimeClks    (bitTime_ff),
        .tstampPulse_ff (tstampPulse_ff)
    );

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Reset parks the controller in configuration mode until software acts
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlag_ff             <= 7'h00;
            irqEnable_ff           <= 7'h00;
            can_pin_control_reg_ff <= `CIT_RST_PINCTRL;
            bitTime_ff             <= `CIT_RST_BITTIME;
            canMode_ff             <= `CIT_RST_MODE;
            comm_status_reg_ff     <= 5'h00;
            evtMask_ff             <= 2'h0;
        end else begin
            irqFlag_ff         <= nxt_flag;
            comm_status_reg_ff <= comm_status_reg_ff | errConditions;
            if (regWrite) begin
                case (regAddr)
                    `CIT_REG_ENABLE:   irqEnable_ff           <= regWdata[6:0];
                    `CIT_REG_CTRLSTAT: canMode_ff             <= regWdata[7:5];
                    `CIT_REG_PINCTRL:  can_pin_control_reg_ff <= regWdata;
                    `CIT_REG_BITTIME:  bitTime_ff             <= regWdata;
                    `CIT_REG_COMMSTAT: comm_status_reg_ff     <= errConditions;
                    `CIT_REG_IRQMASK:  evtMask_ff             <= regWdata[1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Event status, mask and interrupt output
    // ----------------------------------------------------------------
    assign codeChanged = (irqPriorityCode != prevCode_ff);

    // Read of the status clears it, but a new event in that cycle survives
    always @* begin
        nxt_evt = evtStat_ff;
        if (regRead && regAddr == `CIT_REG_IRQSTAT)
            nxt_evt = 2'h0;
        if (frameValidEof && canOwnsPins)
            nxt_evt[`CIT_EV_TSTAMP] = 1'b1;
        if (codeChanged && irqPriorityCode != `CIT_CODE_NONE)
            nxt_evt[`CIT_EV_IRQCODE] = 1'b1;
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            evtStat_ff  <= 2'h0;
            prevCode_ff <= `CIT_CODE_NONE;
            irq_ff      <= 1'b0;
        end else begin
            evtStat_ff  <= nxt_evt;
            prevCode_ff <= irqPriorityCode;
            irq_ff      <= |(nxt_evt & ~evtMask_ff);   // A set mask bit holds its event off
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @* begin
        case (regAddr)
            `CIT_REG_FLAG:     nxt_rdata = {1'b0, irqFlag_ff};
            `CIT_REG_ENABLE:   nxt_rdata = {1'b0, irqEnable_ff};
            `CIT_REG_CTRLSTAT: nxt_rdata = {canMode_ff, 1'b0, irqPriorityCode, 1'b0};
            `CIT_REG_PINCTRL:  nxt_rdata = can_pin_control_reg_ff;
            `CIT_REG_BITTIME:  nxt_rdata = bitTime_ff;
            `CIT_REG_COMMSTAT: nxt_rdata = {3'h0, comm_status_reg_ff};
            `CIT_REG_IRQSTAT:  nxt_rdata = {6'h00, evtStat_ff};
            `CIT_REG_IRQMASK:  nxt_rdata = {6'h00, evtMask_ff};
            default:           nxt_rdata = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            regRdata_ff <= 8'h00;
        else if (regRead)
            regRdata_ff <= nxt_rdata;
        else
            regRdata_ff <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Pin control
    // ----------------------------------------------------------------
    // Every mode but configuration, disable and loopback hands the pins to the controller
    assign canOwnsPins = (canMode_ff != `CIT_MODE_CONFIG) &&
                         (canMode_ff != `CIT_MODE_DISABLE) &&
                         (canMode_ff != `CIT_MODE_LOOPBACK);

    // Recessive is high; with drive-select clear it is driven, else released
    always @* begin
        if (can_pin_control_reg_ff[`CIT_PC_RECDRV]) begin
            nxt_txO  = 1'b0;
            nxt_txOe = !canTxBit;
        end else begin
            nxt_txO  = canTxBit;
            nxt_txOe = 1'b1;
        end
    end

    // Registered pads; direction bits ignored while the controller drives
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            primary_tx_pin_o_ff    <= 1'b0;
            primary_tx_pin_oe_ff   <= 1'b0;
            secondary_tx_pin_o_ff  <= 1'b0;
            secondary_tx_pin_oe_ff <= 1'b0;
            rxPinO_ff              <= 1'b0;
            rxPinOe_ff             <= 1'b0;
        end else begin
            rxPinO_ff  <= portOut[2];
            rxPinOe_ff <= canOwnsPins ? 1'b0 : !port_direction_bits[2];
            if (canOwnsPins) begin
                primary_tx_pin_o_ff  <= nxt_txO;
                primary_tx_pin_oe_ff <= nxt_txOe;
            end else begin
                primary_tx_pin_o_ff  <= portOut[0];
                primary_tx_pin_oe_ff <= !port_direction_bits[0];
            end
            if (canOwnsPins && can_pin_control_reg_ff[`CIT_PC_TX2EN]) begin
                secondary_tx_pin_o_ff  <= nxt_txO;
                secondary_tx_pin_oe_ff <= nxt_txOe;
            end else begin
                secondary_tx_pin_o_ff  <= portOut[1];
                secondary_tx_pin_oe_ff <= !port_direction_bits[1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive input
    // ----------------------------------------------------------------
    // Two-stage synchroniser; idle recessive when the pins belong to the port
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rxMeta_ff    <= 1'b1;
            rxSync_ff    <= 1'b1;
            canRxBit_ff  <= 1'b1;
            portRxBit_ff <= 1'b1;
        end else begin
            rxMeta_ff    <= rxPinIn;
            rxSync_ff    <= rxMeta_ff;
            canRxBit_ff  <= canOwnsPins ? rxSync_ff : 1'b1;
            portRxBit_ff <= rxSync_ff;
        end
    end

endmodule
`default_nettype wire

// *** rtl/cit_prio_enc.v ***
// Priority encoder turning qualified interrupt flags into a 3-bit code
`timescale 1ns/100ps
`default_nettype none
`include "cit_defs.vh"

module cit_prio_enc (
    // Flags and enables
    input  wire [6:0] irqFlags,
    input  wire [6:0] irqEnables,
    // Result
    output reg  [2:0] irqCode
);

    wire [6:0] qual;

    // A source counts only when flag and enable are both set
    assign qual = irqFlags & irqEnables;

    // Fixed order: error, tx a, b, c, rx a, b, wake-up
    always @* begin
        if (qual[`CIT_B_ERR])
            irqCode = `CIT_CODE_ERR;
        else if (qual[`CIT_B_TXA])
            irqCode = `CIT_CODE_TXA;
        else if (qual[`CIT_B_TXB])
            irqCode = `CIT_CODE_TXB;
        else if (qual[`CIT_B_TXC])
            irqCode = `CIT_CODE_TXC;
        else if (qual[`CIT_B_RXA])
            irqCode = `CIT_CODE_RXA;
        else if (qual[`CIT_B_RXB])
            irqCode = `CIT_CODE_RXB;
        else if (qual[`CIT_B_WAK])
            irqCode = `CIT_CODE_WAK;
        else
            irqCode = `CIT_CODE_NONE;
    end

endmodule
`default_nettype wire

// *** rtl/cit_tstamp.v ***
// One-bit-time timestamp pulse generator after a valid end of frame
`timescale 1ns/100ps
`default_nettype none
`include "cit_defs.vh"

module cit_tstamp (
    // Clock and reset
    input  wire                  mclk,
    input  wire                  arst_n,
    // Control
    input  wire                  frameOk,
    input  wire [`CIT_BT_W-1:0]  bitTimeClks,
    // Output
    output reg                   tstampPulse_ff
);

    reg  [`CIT_BT_W-1:0] cnt_ff;

    // Pulse rises on the cycle after the good EOF and lasts bitTimeClks+1 cycles
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tstampPulse_ff <= 1'b0;
            cnt_ff         <= {`CIT_BT_W{1'b0}};
        end else if (frameOk) begin
            tstampPulse_ff <= 1'b1;
            cnt_ff         <= bitTimeClks;
        end else if (tstampPulse_ff) begin
            if (cnt_ff == {`CIT_BT_W{1'b0}})
                tstampPulse_ff <= 1'b0;
            else
                cnt_ff <= cnt_ff - 1'b1;
        end
    end

endmodule
`default_nettype wire

// *** verification/cit_can_tail_checker.sv ***
// Concurrent checks on the ports of the CAN tail block
`timescale 1ns/100ps
`default_nettype none
module cit_can_tail_checker (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // Engine and port side
    input wire logic       frameValidEof,
    input wire logic       canTxBit,
    input wire logic [2:0] portOut,
    input wire logic [2:0] port_direction_bits,
    input wire logic       rxPinIn,
    // Pads and status
    input wire logic       primary_tx_pin_o_ff,
    input wire logic       primary_tx_pin_oe_ff,
    input wire logic       secondary_tx_pin_o_ff,
    input wire logic       secondary_tx_pin_oe_ff,
    input wire logic       rxPinOe_ff,
    input wire logic       canRxBit_ff,
    input wire logic       tstampPulse_ff,
    input wire logic [2:0] canMode_ff
);
    // ------------------------------------------------------------
    // Pad ownership and timing relations
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Modes in which the port logic owns every pin
    wire logic portOwned = (canMode_ff == 3'h1) || (canMode_ff == 3'h2) || (canMode_ff == 3'h4);

    a_stamp_start: assert property (frameValidEof && canMode_ff == 3'h0 |=> tstampPulse_ff)
        else $error("timestamp missing after valid frame");
    a_stamp_cause: assert property ($rose(tstampPulse_ff) |-> $past(frameValidEof))
        else $error("timestamp rose without a valid frame");
    // Pads settle one cycle after their cause, so compare against last cycle's inputs
    a_port_pri: assert property ($past(arst_n) && $past(portOwned) && portOwned |->
        primary_tx_pin_oe_ff == !$past(port_direction_bits[0]) &&
        (!primary_tx_pin_oe_ff || primary_tx_pin_o_ff == $past(portOut[0])))
        else $error("primary pin not under port control");
    a_port_sec: assert property ($past(arst_n) && $past(portOwned) && portOwned |->
        secondary_tx_pin_oe_ff == !$past(port_direction_bits[1]) && rxPinOe_ff == !$past(port_direction_bits[2]))
        else $error("secondary or receive pin not under port control");
    a_drive_dom: assert property ($past(arst_n) && $past(canMode_ff) == 3'h0 && !$past(canTxBit) |->
        primary_tx_pin_oe_ff && !primary_tx_pin_o_ff)
        else $error("dominant bit not driven on primary pin");
    a_rx_owned: assert property ((canMode_ff == 3'h4)[*4] |-> canRxBit_ff)
        else $error("engine sees bus data in configuration mode");
    a_rx_follow: assert property ((canMode_ff == 3'h0 && $stable(rxPinIn))[*4] |-> canRxBit_ff == rxPinIn)
        else $error("engine receive bit does not follow the pin");
    a_mode_init: assert property (!$past(arst_n) |-> canMode_ff == 3'h4)
        else $error("mode after reset is not configuration");
endmodule
`default_nettype wire

// *** verification/cit_can_tail_tb.sv ***
// Self-checking bench for the CAN tail block with a transceiver model
`timescale 1ns/100ps
`default_nettype none
module cit_can_tail_tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic       mclk, arst_n, regWrite, regRead, frameValidEof, canTxBit, remoteDom, rxPinIn;
    logic [3:0] regAddr;
    logic [7:0] regWdata, rd, regRdata;
    logic [6:0] irqSetEvents, fl, en;
    logic [4:0] errConditions;
    logic [2:0] portOut, dirBits, mode, canMode;
    logic [1:0] pc, ePri, eSec, eRx;
    logic       txaO, txaOe, txbO, txbOe, rxOe, rxO, canRx, portRx, stamp, irq, own, bus;
    integer     seed, badCount, numChecks, i, k, n;

    cit_can_tail dut (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata_ff(regRdata), .irqSetEvents(irqSetEvents), .errConditions(errConditions),
        .frameValidEof(frameValidEof), .canTxBit(canTxBit), .portOut(portOut), .port_direction_bits(dirBits),
        .rxPinIn(rxPinIn), .primary_tx_pin_o_ff(txaO), .primary_tx_pin_oe_ff(txaOe), .secondary_tx_pin_o_ff(txbO),
        .secondary_tx_pin_oe_ff(txbOe), .rxPinOe_ff(rxOe), .rxPinO_ff(rxO), .canRxBit_ff(canRx),
        .portRxBit_ff(portRx), .tstampPulse_ff(stamp), .canMode_ff(canMode), .irq_ff(irq));
    cit_xcvr_model xcvr (.txaO(txaO), .txaOe(txaOe), .txbO(txbO), .txbOe(txbOe), .remoteDom(remoteDom),
        .rxLevel(rxPinIn));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Code of the highest qualified source; bit 0 has top priority, so it is applied last
    function automatic logic [2:0] prioCode(input logic [6:0] q);
        logic [20:0] tbl;
        tbl = 21'b111_101_110_010_011_100_001;
        prioCode = 3'h0;
        for (int b = 6; b >= 0; b--) if (q[b]) prioCode = tbl[b*3 +: 3];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        numChecks = numChecks + 1;
        if (seen !== exp) begin
            badCount = badCount + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdReg(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask

    // Counts the cycles the pulse stays high; bounded so a stuck pulse cannot hang the run
    task automatic stampLen(input logic [7:0] expLen);
        @(posedge mclk);
        frameValidEof <= 1'b1;
        @(posedge mclk);
        frameValidEof <= 1'b0;
        #1 n = 0;
        while (stamp === 1'b1 && n < 300) begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        check(n[7:0], expLen);
        if (n >= 300) testDone;
    endtask

    task testDone;
        if (badCount == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Main sequence
    initial begin
        seed = 32'h2534;
        badCount = 0;
        numChecks = 0;
        arst_n = 1'b0;
        {regWrite, regRead, frameValidEof, remoteDom} = 4'h0;
        {regAddr, regWdata, irqSetEvents, errConditions, portOut} = 0;
        canTxBit = 1'b1;
        dirBits = 3'h7;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        // Reset values, including an unmapped address
        rdReg(4'h2);
        check(rd, 8'h80);
        rdReg(4'h4);
        check(rd, 8'h13);
        rdReg(4'hc);
        check(rd, 8'h00);
        // Walk-down from all sources pending, then random flag and enable mixes
        for (i = 0; i < 24; i = i + 1) begin
            fl = (i < 8) ? 7'h7f << i : $random(seed);
            en = (i < 8) ? 7'h7f : $random(seed);
            wr(4'h1, {1'b0, en});
            wr(4'h0, {1'b0, fl});
            rdReg(4'h2);
            check(rd, {3'h4, 1'b0, prioCode(fl & en), 1'b0});
        end
        // Each event in turn, the first five each paired with one error condition
        wr(4'h0, 8'h00);
        for (k = 0; k < 7; k = k + 1) begin
            @(posedge mclk);
            irqSetEvents  <= 7'h01 << k;
            errConditions <= (k < 5) ? 5'h01 << k : 5'h00;
            @(posedge mclk);
            irqSetEvents  <= 7'h00;
            errConditions <= 5'h00;
            rdReg(4'h0);
            check(rd, (8'h01 << k) | ((k < 5) ? 8'h01 : 8'h00));
            rdReg(4'h5);
            check({3'h0, rd[4:0]}, (k < 5) ? 8'h01 << k : 8'h00);
            wr(4'h0, 8'h00);
            wr(4'h5, 8'h00);
        end
        // New-code event raises the interrupt, a status read clears it, a mask holds it off
        wr(4'h1, 8'h7f);
        rdReg(4'h6);
        wr(4'h7, 8'h00);
        wr(4'h0, 8'h01);
        repeat (2) @(posedge mclk);
        #1 check({7'h00, irq}, 8'h01);
        rdReg(4'h6);
        check(rd & 8'h02, 8'h02);
        #30 check({7'h00, irq}, 8'h00);
        wr(4'h7, 8'h02);
        wr(4'h0, 8'h02);
        repeat (2) @(posedge mclk);
        #1 check({7'h00, irq}, 8'h00);
        // Timestamp at the reset bit time, then at a short one
        wr(4'h2, 8'h00);
        stampLen(8'd20);
        wr(4'h4, 8'h04);
        stampLen(8'd5);
        check({7'h00, irq}, 8'h01);
        rdReg(4'h6);
        check(rd & 8'h01, 8'h01);
        // Pads in every mode with random pin-control, port and bus values
        for (i = 0; i < 40; i = i + 1) begin
            mode = i % 5;
            pc = $random(seed);
            @(posedge mclk);
            canTxBit  <= $random(seed);
            portOut   <= $random(seed);
            dirBits   <= $random(seed);
            remoteDom <= $random(seed);
            wr(4'h3, {6'h00, pc});
            wr(4'h2, {mode, 5'h00});
            repeat (4) @(posedge mclk);
            #1 own = (mode == 3'h0) || (mode == 3'h3);
            ePri = own ? {!pc[1] || !canTxBit, canTxBit} : {!dirBits[0], dirBits[0] | portOut[0]};
            eSec = (own && pc[0]) ? ePri : {!dirBits[1], dirBits[1] | portOut[1]};
            eRx  = own ? 2'b01 : {!dirBits[2], dirBits[2] | portOut[2]};
            check({2'b00, txaOe, txaOe ? txaO : 1'b1, txbOe, txbOe ? txbO : 1'b1, rxOe, rxOe ? rxO : 1'b1},
                  {2'b00, ePri, eSec, eRx});
            bus = !(remoteDom || (ePri == 2'b10) || (eSec == 2'b10));
            if (mode != 3'h2) check({7'h00, canRx}, {7'h00, own ? bus : 1'b1});
        end
        testDone;
    end
endmodule

bind cit_can_tail cit_can_tail_checker chkr (.mclk(mclk), .arst_n(arst_n), .frameValidEof(frameValidEof),
    .canTxBit(canTxBit), .portOut(portOut), .port_direction_bits(port_direction_bits), .rxPinIn(rxPinIn),
    .primary_tx_pin_o_ff(primary_tx_pin_o_ff), .primary_tx_pin_oe_ff(primary_tx_pin_oe_ff),
    .secondary_tx_pin_o_ff(secondary_tx_pin_o_ff), .secondary_tx_pin_oe_ff(secondary_tx_pin_oe_ff),
    .rxPinOe_ff(rxPinOe_ff), .canRxBit_ff(canRxBit_ff), .tstampPulse_ff(tstampPulse_ff), .canMode_ff(canMode_ff));
`default_nettype wire

// *** verification/cit_xcvr_model.sv ***
// Behavioural CAN transceiver on the far side of the tail block's pads
`timescale 1ns/100ps
`default_nettype none
module cit_xcvr_model (
    // Pads of the tail block
    input  wire logic txaO,
    input  wire logic txaOe,
    input  wire logic txbO,
    input  wire logic txbOe,
    // Other nodes pulling the bus dominant
    input  wire logic remoteDom,
    // Bus level returned to the receive pad
    output wire logic rxLevel
);
    // Wired-AND bus with pull-up: a released line reads recessive, any driven zero wins
    assign rxLevel = !(remoteDom || (txaOe && !txaO) || (txbOe && !txbO));
endmodule
`default_nettype wire
